/* shared/epbc_pkg.sv */
// Purpose: Constants for the protected page cache page-block leaf unit
// Assumes: One clock, AHB-Lite register access, 32-bit data words
// Notes:   Status codes and page type codes are fixed table values
`default_nettype none

package epbc_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_LEAF       = 8'h00;
  localparam logic [7:0] OFS_ADDR_LO    = 8'h04;
  localparam logic [7:0] OFS_RESULT     = 8'h08;
  localparam logic [7:0] OFS_FLAGS      = 8'h0C;
  localparam logic [7:0] OFS_STATUS     = 8'h10;
  localparam logic [7:0] OFS_FAULT_ADDR = 8'h14;
  localparam logic [7:0] OFS_MODE       = 8'h18;
  localparam logic [7:0] OFS_DS_BASE    = 8'h1C;
  localparam logic [7:0] OFS_DS_LIMIT   = 8'h20;
  localparam logic [7:0] OFS_CACHE_BASE = 8'h24;
  localparam logic [7:0] OFS_MAP_SEL    = 8'h28;
  localparam logic [7:0] OFS_MAP_DATA   = 8'h2C;
  localparam logic [7:0] OFS_ADDR_HI    = 8'h30;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FLG_CARRY  = 0;
  localparam int FLG_PARITY = 2;
  localparam int FLG_AUX    = 4;
  localparam int FLG_ZERO   = 6;
  localparam int FLG_SIGN   = 7;
  localparam int FLG_OVFL   = 11;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_GP   = 2;
  localparam int ST_PFX  = 3;
  localparam int MAP_VALID = 0;
  localparam int MAP_BLOCKED = 1;
  localparam int MAP_TYPE_LSB = 4;
  localparam int PAGE_SHIFT = 12;
  localparam int CANON_MSB = 47;

  // ----------------------------------------------------------------
  // Leaf selector, page types, status codes
  // ----------------------------------------------------------------
  localparam logic [7:0] LEAF_PAGE_BLOCK = 8'h09;
  localparam logic [2:0] regular_page_type        = 3'h0;
  localparam logic [2:0] control_page_type        = 3'h1;
  localparam logic [2:0] thread_control_page_type = 3'h2;
  localparam logic [2:0] trimmed_page_type        = 3'h4;
  localparam logic [2:0] shadow_stack_first_type  = 3'h5;
  localparam logic [2:0] shadow_stack_rest_type   = 3'h6;
  localparam logic [31:0] success_code             = 32'h0000_0000;
  localparam logic [31:0] already_blocked_code     = 32'h0000_0001;
  localparam logic [31:0] epoch_locked_code        = 32'h0000_0002;
  localparam logic [31:0] not_blockable_code       = 32'h0000_0003;
  localparam logic [31:0] invalid_page_code        = 32'h0000_0004;
  localparam logic [31:0] page_conflict_code       = 32'h0000_0005;
  localparam logic [31:0] control_page_status_code = 32'h0000_0006;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_DS_LIMIT = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_WORD     = 32'h0000_0000;

  typedef enum {ST_IDLE, ST_CHECK, ST_LOOKUP} epbc_state_t;

endpackage : epbc_pkg

`default_nettype wire

/* logic/epbc_page_block.sv */
// Purpose: Page-block leaf execution unit with AHB-Lite register access
// Assumes: Writer/tracking busy inputs come from logic on the same clock
// Notes:   Zero wait-state slave; leaf completes two cycles after start on a fault, three after a lookup
//
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module epbc_page_block
  import epbc_pkg::*;
#(
  parameter int PAGES = 16
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        page_write_busy,
  input  wire logic [$clog2(PAGES)-1:0] page_write_idx,
  input  wire logic        epoch_update_busy,
  input  wire logic        cache_resource_locked,
  input  wire logic        access_fault,
  output logic             leaf_done
);

  localparam int IW = $clog2(PAGES);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  epbc_state_t state_q;
  logic [6:0]  map_q [PAGES];
  logic [31:0] result_q;
  logic [11:0] flags_q;
  logic        gp_q;
  logic        pfx_q;
  logic        done_q;
  logic [63:0] fault_addr_q;
  logic [31:0] addr_lo_q;
  logic [31:0] addr_hi_q;
  logic [2:0]  mode_q;
  logic [31:0] ds_base_q;
  logic [31:0] ds_limit_q;
  logic [31:0] cache_base_q;
  logic [IW-1:0] map_sel_q;
  logic [IW-1:0] idx_q;
  logic [63:0] ea_q;
  logic        a_wr_q;
  logic        a_rd;
  logic [7:0]  a_ofs_q;
  logic [31:0] hrdata_q;
  logic        hreadyout_q;
  logic        hresp_q;
  logic        leaf_done_q;

  // Offset within the bus word window
  function automatic logic [7:0] word_ofs(input logic [31:0] a);
    word_ofs = {a[7:2], 2'b00};
  endfunction : word_ofs

  // Page types that may be blocked
  function automatic logic blockable(input logic [2:0] t);
    blockable = (t == regular_page_type) || (t == thread_control_page_type) ||
                (t == trimmed_page_type) || (t == shadow_stack_first_type) ||
                (t == shadow_stack_rest_type);
  endfunction : blockable

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic a_take;
  logic a_wr_now;
  logic start;
  assign a_take   = hsel && htrans[1] && hready;
  assign a_rd     = a_take && !hwrite;
  assign a_wr_now = a_wr_q;
  // A leaf write while busy is dropped; the unit has one context
  assign start    = a_wr_now && (a_ofs_q == OFS_LEAF) &&
                    (hwdata[7:0] == LEAF_PAGE_BLOCK) && (state_q == ST_IDLE);

  // Address phase capture; every access answers at once with OKAY
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      a_wr_q      <= 1'b0;
      a_ofs_q     <= 8'h00;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else begin
      a_wr_q      <= a_take && hwrite;
      a_ofs_q     <= word_ofs(haddr);
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end
  end

  // Read data registered during the address phase; unmapped reads zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hrdata_q <= 32'h0000_0000;
    end else if (a_rd) begin
      unique case (word_ofs(haddr))
        OFS_ADDR_LO:    hrdata_q <= addr_lo_q;
        OFS_ADDR_HI:    hrdata_q <= addr_hi_q;
        OFS_RESULT:     hrdata_q <= result_q;
        OFS_FLAGS:      hrdata_q <= {20'h00000, flags_q};
        OFS_STATUS:     hrdata_q <= {28'h0000000, pfx_q, gp_q, done_q,
                                     state_q != ST_IDLE};
        OFS_FAULT_ADDR: hrdata_q <= fault_addr_q[31:0];
        OFS_MODE:       hrdata_q <= {29'h0, mode_q};
        OFS_DS_BASE:    hrdata_q <= ds_base_q;
        OFS_DS_LIMIT:   hrdata_q <= ds_limit_q;
        OFS_CACHE_BASE: hrdata_q <= cache_base_q;
        OFS_MAP_SEL:    hrdata_q <= {{(32-IW){1'b0}}, map_sel_q};
        OFS_MAP_DATA:   hrdata_q <= {25'h0, map_q[map_sel_q]};
        default:        hrdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Software configuration registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_lo_q    <= RST_WORD;
      addr_hi_q    <= RST_WORD;
      mode_q       <= 3'h0;
      ds_base_q    <= RST_WORD;
      ds_limit_q   <= RST_DS_LIMIT;
      cache_base_q <= RST_WORD;
      map_sel_q    <= '0;
    end else if (a_wr_now) begin
      unique case (a_ofs_q)
        OFS_ADDR_LO:    addr_lo_q    <= hwdata;
        OFS_ADDR_HI:    addr_hi_q    <= hwdata;
        OFS_MODE:       mode_q       <= hwdata[2:0];
        OFS_DS_BASE:    ds_base_q    <= hwdata;
        OFS_DS_LIMIT:   ds_limit_q   <= hwdata;
        OFS_CACHE_BASE: cache_base_q <= hwdata;
        OFS_MAP_SEL:    map_sel_q    <= hwdata[IW-1:0];
        default:        ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Address formation and checks
  // ----------------------------------------------------------------
  logic        cpl_zero;
  logic        mode64;
  logic [63:0] ea_now;
  logic [63:0] lin_now;
  logic        seg_bad;
  logic        align_bad;
  logic [63:0] cache_off;
  logic        out_cache;
  logic        gp_cond;
  logic        pf_cond;
  assign cpl_zero = (mode_q[1:0] == 2'b00);
  assign mode64   = mode_q[2];
  assign ea_now   = mode64 ? {addr_hi_q, addr_lo_q} : {32'h0000_0000, addr_lo_q};
  // Data segment base only; no override path exists
  assign lin_now  = mode64 ? ea_q : {32'h0000_0000, ds_base_q + ea_q[31:0]};
  assign seg_bad  = mode64 ? (ea_q[63:CANON_MSB] != {17{ea_q[CANON_MSB]}})
                           : (ea_q[31:0] > ds_limit_q);
  assign align_bad = (ea_q[PAGE_SHIFT-1:0] != 12'h000);
  assign cache_off = lin_now - {32'h0000_0000, cache_base_q};
  assign out_cache = (lin_now < {32'h0000_0000, cache_base_q}) ||
                     (cache_off[63:PAGE_SHIFT] >= 52'(PAGES));
  assign gp_cond  = !cpl_zero || seg_bad || align_bad || cache_resource_locked;
  assign pf_cond  = out_cache || access_fault;

  // ----------------------------------------------------------------
  // Leaf sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      ea_q    <= 64'h0;
      idx_q   <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: if (start) begin
          ea_q    <= ea_now;
          state_q <= ST_CHECK;
        end
        ST_CHECK: begin
          idx_q   <= cache_off[PAGE_SHIFT+IW-1:PAGE_SHIFT];
          state_q <= (gp_cond || pf_cond) ? ST_IDLE : ST_LOOKUP;
        end
        ST_LOOKUP: state_q <= ST_IDLE;
      endcase
    end
  end

  // Map entry seen by the lookup stage
  logic [6:0] ent;
  logic       ent_valid;
  logic       ent_blocked;
  logic [2:0] ent_type;
  logic       conflict;
  assign ent         = map_q[idx_q];
  assign ent_valid   = ent[MAP_VALID];
  assign ent_blocked = ent[MAP_BLOCKED];
  assign ent_type    = ent[MAP_TYPE_LSB+2:MAP_TYPE_LSB];
  // Shared access: only a writer on the same page conflicts
  assign conflict    = page_write_busy && (page_write_idx == idx_q);

  // Faults, result and flags; checks run in priority order
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gp_q         <= 1'b0;
      pfx_q        <= 1'b0;
      done_q       <= 1'b0;
      result_q     <= success_code;
      flags_q      <= 12'h000;
      fault_addr_q <= 64'h0;
      leaf_done_q  <= 1'b0;
    end else begin
      leaf_done_q <= 1'b0;
      if (start) begin
        gp_q   <= 1'b0;
        pfx_q  <= 1'b0;
        done_q <= 1'b0;
      end
      if (state_q == ST_CHECK && gp_cond) begin
        gp_q        <= 1'b1;
        done_q      <= 1'b1;
        leaf_done_q <= 1'b1;
      end else if (state_q == ST_CHECK && pf_cond) begin
        pfx_q        <= 1'b1;
        fault_addr_q <= lin_now;
        done_q       <= 1'b1;
        leaf_done_q  <= 1'b1;
      end
      if (state_q == ST_LOOKUP) begin
        done_q      <= 1'b1;
        leaf_done_q <= 1'b1;
        flags_q     <= 12'h000;
        result_q    <= success_code;
        if (conflict) begin
          flags_q[FLG_ZERO] <= 1'b1;
          result_q          <= page_conflict_code;
        end else if (!ent_valid) begin
          flags_q[FLG_ZERO] <= 1'b1;
          result_q          <= invalid_page_code;
        end else if (!blockable(ent_type)) begin
          flags_q[FLG_CARRY] <= 1'b1;
          result_q           <= (ent_type == control_page_type) ?
                                control_page_status_code : not_blockable_code;
        end else if (ent_blocked) begin
          flags_q[FLG_CARRY] <= 1'b1;
          result_q           <= already_blocked_code;
        end else if (epoch_update_busy) begin
          result_q <= epoch_locked_code;
        end
      end
    end
  end

  // Map entries: software loads them; the leaf only sets blocked.
  // A writer on the same page or a busy epoch update stops this path.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < PAGES; i++) begin
        map_q[i] <= 7'h00;
      end
    end else if (state_q == ST_LOOKUP && !conflict && ent_valid &&
                 blockable(ent_type) && !ent_blocked && !epoch_update_busy) begin
      map_q[idx_q][MAP_BLOCKED] <= 1'b1;
    end else if (a_wr_now && a_ofs_q == OFS_MAP_DATA) begin
      map_q[map_sel_q] <= hwdata[6:0];
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;
  assign leaf_done = leaf_done_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_leaf_start: assert property (
    start |=> state_q == ST_CHECK ##1 state_q != ST_CHECK)
    else $error("leaf start did not enter check");

  chk_cpl_refuse: assert property (
    (state_q == ST_CHECK && !cpl_zero) |=> gp_q && state_q == ST_IDLE && leaf_done_q)
    else $error("nonzero privilege not refused");

  chk_align_gp: assert property (
    (state_q == ST_CHECK && align_bad) |=> gp_q && !pfx_q && $stable(result_q))
    else $error("unaligned address did not fault");

  chk_range_pf: assert property (
    (state_q == ST_CHECK && !gp_cond && out_cache) |=>
      pfx_q && fault_addr_q == $past(lin_now))
    else $error("page fault missing or wrong address");

  chk_flags_clear: assert property (
    (state_q == ST_LOOKUP) |=> !flags_q[FLG_PARITY] && !flags_q[FLG_AUX] &&
      !flags_q[FLG_OVFL] && !flags_q[FLG_SIGN])
    else $error("arithmetic flags not cleared");

  chk_conflict_code: assert property (
    (state_q == ST_LOOKUP && conflict) |=>
      result_q == page_conflict_code && flags_q[FLG_ZERO] && !flags_q[FLG_CARRY])
    else $error("conflict not reported");

  chk_invalid_code: assert property (
    (state_q == ST_LOOKUP && !conflict && !ent_valid) |=>
      result_q == invalid_page_code && flags_q[FLG_ZERO])
    else $error("invalid page not reported");

  chk_already_blocked: assert property (
    (state_q == ST_LOOKUP && !conflict && ent_valid && blockable(ent_type) && ent_blocked)
      |=> result_q == already_blocked_code && flags_q[FLG_CARRY] && !flags_q[FLG_ZERO])
    else $error("already blocked not reported");

  chk_block_set: assert property (
    (state_q == ST_LOOKUP && !conflict && ent_valid && blockable(ent_type) &&
     !ent_blocked && !epoch_update_busy) |=>
      map_q[$past(idx_q)][MAP_BLOCKED] && result_q == success_code && flags_q == 12'h000)
    else $error("page was not blocked");

  chk_epoch_lock: assert property (
    (state_q == ST_LOOKUP && !conflict && ent_valid && blockable(ent_type) &&
     !ent_blocked && epoch_update_busy) |=>
      result_q == epoch_locked_code && !map_q[$past(idx_q)][MAP_BLOCKED])
    else $error("epoch lock not honoured");

  chk_leaf_refuse: assert property (
    (a_wr_now && a_ofs_q == OFS_LEAF && hwdata[7:0] != LEAF_PAGE_BLOCK &&
     state_q == ST_IDLE) |=> state_q == ST_IDLE)
    else $error("foreign selector started a leaf");

  chk_limit_gp: assert property (
    (state_q == ST_CHECK && !mode64 && ea_q[31:0] > ds_limit_q) |=> gp_q && leaf_done_q)
    else $error("segment limit not enforced");

  chk_canon_gp: assert property (
    (state_q == ST_CHECK && mode64 && ea_q[63:CANON_MSB] != {17{ea_q[CANON_MSB]}}) |=>
      gp_q && leaf_done_q)
    else $error("non-canonical address not refused");

  chk_lock_gp: assert property (
    (state_q == ST_CHECK && cache_resource_locked) |=> gp_q && !pfx_q)
    else $error("locked resource did not fault");

  chk_access_pf: assert property (
    (state_q == ST_CHECK && !gp_cond && access_fault) |=> pfx_q && !gp_q && leaf_done_q)
    else $error("access fault not reported");

  chk_type_refuse: assert property (
    (state_q == ST_LOOKUP && !conflict && ent_valid && !blockable(ent_type)) |=>
      flags_q[FLG_CARRY] && !flags_q[FLG_ZERO])
    else $error("unblockable type not refused");

  chk_control_code: assert property (
    (state_q == ST_LOOKUP && !conflict && ent_valid && ent_type == control_page_type) |=>
      result_q == control_page_status_code)
    else $error("control page code missing");

  chk_unblockable_code: assert property (
    (state_q == ST_LOOKUP && !conflict && ent_valid && !blockable(ent_type) &&
     ent_type != control_page_type) |=> result_q == not_blockable_code)
    else $error("not-blockable code missing");

endmodule : epbc_page_block

`default_nettype wire

/* tb/epbc_sw_model.sv */
// Purpose: Software-side model that issues page-block leaf requests over AHB-Lite
// Assumes: One slave whose hreadyout is the bus hready; whole-word single transfers
// Notes:   Waits are open here; the bench watchdog cuts a hang short
`timescale 1ns/1ps
`default_nettype none

module epbc_sw_model
  import epbc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  input  wire logic        leaf_done,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  // Idle bus from time zero
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // Write data is inverted after release so a stale value can never pass for fresh
  task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, ofs};
    htrans <= 2'h2;
    hwrite <= wr;
    do begin @(posedge clk); end while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge clk); end while (hready !== 1'b1);
    q = hrdata;
    hwdata <= ~d;
  endtask : xfer

  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, ofs, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] ofs, output logic [31:0] q);
    xfer(1'b0, ofs, 32'h0000_0000, q);
  endtask : rd

  // Start the leaf on one page and wait for its completion pulse
  task automatic leaf(input logic [31:0] a);
    wr(OFS_ADDR_LO, a);
    wr(OFS_LEAF, {24'h00_0000, LEAF_PAGE_BLOCK});
    do begin @(posedge clk); end while (leaf_done !== 1'b1);
  endtask : leaf

  // An epoch lock is transient, so software just issues the leaf again
  task automatic leaf_retry(input logic [31:0] a);
    logic [31:0] r;
    do begin leaf(a); rd(OFS_RESULT, r); end while (r === epoch_locked_code);
  endtask : leaf_retry
endmodule : epbc_sw_model

`default_nettype wire

/* tb/tb_top.sv */
// Purpose: Self-checking bench for the page-block leaf unit
// Assumes: Partner model drives the register bus; bench drives the busy inputs
// Notes:   Table rows cover page types; faults and concurrency are hand-written
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import epbc_pkg::*;
;
  localparam int          NP = 4;
  localparam logic [31:0] CB = 32'h0010_0000;
  // Map entry before the leaf, expected result, flags, map entry after
  typedef struct packed {
    logic [6:0]  ent;
    logic [31:0] res;
    logic [31:0] flg;
    logic [6:0]  post;
  } epbc_row_t;
  // Entry layout: [6:4] type, [1] blocked, [0] valid; carry flag is 01, zero flag is 40
  epbc_row_t rows [10] = '{
    '{7'h01, success_code, 32'h0, 7'h03}, '{7'h21, success_code, 32'h0, 7'h23},
    '{7'h41, success_code, 32'h0, 7'h43}, '{7'h51, success_code, 32'h0, 7'h53},
    '{7'h61, success_code, 32'h0, 7'h63}, '{7'h11, control_page_status_code, 32'h1, 7'h11},
    '{7'h31, not_blockable_code, 32'h1, 7'h31}, '{7'h71, not_blockable_code, 32'h1, 7'h71},
    '{7'h02, invalid_page_code, 32'h40, 7'h02}, '{7'h03, already_blocked_code, 32'h1, 7'h03}};

  logic        clk;
  logic        nrst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        page_write_busy;
  logic [1:0]  page_write_idx;
  logic        epoch_update_busy;
  logic        cache_resource_locked;
  logic        access_fault;
  logic        leaf_done;
  int          err_total;
  int          check_count;
  int          done_seen;
  int          n0;
  logic [31:0] rv;

  // ------------------------------------------------------------
  // Instances, clock, monitors
  // ------------------------------------------------------------
  epbc_page_block #(.PAGES(NP)) epbc_page_block_i (
    .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .page_write_busy(page_write_busy), .page_write_idx(page_write_idx),
    .epoch_update_busy(epoch_update_busy), .cache_resource_locked(cache_resource_locked),
    .access_fault(access_fault), .leaf_done(leaf_done));

  epbc_sw_model epbc_sw_model_i (
    .clk(clk), .hready(hreadyout), .hrdata(hrdata), .leaf_done(leaf_done), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Count completion pulses so ignored starts can be seen
  always @(posedge clk) begin
    if (leaf_done === 1'b1) done_seen++;
  end

  // Leaves finish in a few cycles; this span is far beyond the whole run
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    results();
  end

  // ------------------------------------------------------------
  // Checking tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic rdc(input logic [7:0] ofs, input logic [31:0] exp);
    epbc_sw_model_i.rd(ofs, rv);
    chk(rv, exp);
  endtask : rdc

  task automatic map_set(input logic [31:0] idx, input logic [6:0] ent);
    epbc_sw_model_i.wr(OFS_MAP_SEL, idx);
    epbc_sw_model_i.wr(OFS_MAP_DATA, {25'h0, ent});
  endtask : map_set

  // Status 2 is done, 6 done with protection fault, A done with page fault
  task automatic leaf_chk(input logic [31:0] a, input logic [31:0] res,
                          input logic [31:0] flg, input logic [31:0] sts);
    epbc_sw_model_i.leaf(a);
    rdc(OFS_RESULT, res);
    rdc(OFS_FLAGS, flg);
    rdc(OFS_STATUS, sts);
  endtask : leaf_chk

  task automatic results();
    if (err_total == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    page_write_busy = 1'b0;
    page_write_idx = 2'h0;
    epoch_update_busy = 1'b0;
    cache_resource_locked = 1'b0;
    access_fault = 1'b0;
    err_total = 0;
    check_count = 0;
    done_seen = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    epbc_sw_model_i.wr(OFS_CACHE_BASE, CB);
    foreach (rows[i]) begin
      map_set(i % NP, rows[i].ent);
      leaf_chk(CB + (i % NP) * 4096, rows[i].res, rows[i].flg, 32'h2);
      rdc(OFS_MAP_DATA, {25'h0, rows[i].post});
    end
    // Faults leave result and flags as the last leaf left them
    map_set(2, 7'h01);
    leaf_chk(CB + 32'h2004, already_blocked_code, 32'h1, 32'h6);
    leaf_chk(CB + NP * 4096, already_blocked_code, 32'h1, 32'hA);
    rdc(OFS_FAULT_ADDR, CB + NP * 4096);
    @(posedge clk) cache_resource_locked <= 1'b1;
    leaf_chk(CB + 32'h2000, already_blocked_code, 32'h1, 32'h6);
    @(posedge clk) cache_resource_locked <= 1'b0;
    access_fault <= 1'b1;
    leaf_chk(CB + 32'h2000, already_blocked_code, 32'h1, 32'hA);
    @(posedge clk) access_fault <= 1'b0;
    epbc_sw_model_i.wr(OFS_MODE, 32'h3);
    leaf_chk(CB + 32'h2000, already_blocked_code, 32'h1, 32'h6);
    epbc_sw_model_i.wr(OFS_MODE, 32'h0);
    epbc_sw_model_i.wr(OFS_DS_LIMIT, CB + 32'h1FFF);
    leaf_chk(CB + 32'h2000, already_blocked_code, 32'h1, 32'h6);
    epbc_sw_model_i.wr(OFS_DS_LIMIT, 32'hFFFF_FFFF);
    rdc(OFS_MAP_DATA, 32'h01);
    // A writer on this page conflicts, a writer elsewhere does not
    @(posedge clk) page_write_busy <= 1'b1;
    page_write_idx <= 2'h2;
    leaf_chk(CB + 32'h2000, page_conflict_code, 32'h40, 32'h2);
    rdc(OFS_MAP_DATA, 32'h01);
    @(posedge clk) page_write_idx <= 2'h3;
    leaf_chk(CB + 32'h2000, success_code, 32'h0, 32'h2);
    rdc(OFS_MAP_DATA, 32'h03);
    @(posedge clk) page_write_busy <= 1'b0;
    // Epoch lock: no block, then the retry succeeds once the lock drops
    map_set(3, 7'h01);
    @(posedge clk) epoch_update_busy <= 1'b1;
    leaf_chk(CB + 32'h3000, epoch_locked_code, 32'h0, 32'h2);
    rdc(OFS_MAP_DATA, 32'h01);
    fork
      begin repeat (12) @(posedge clk); epoch_update_busy <= 1'b0; end
      epbc_sw_model_i.leaf_retry(CB + 32'h3000);
    join
    rdc(OFS_MAP_DATA, 32'h03);
    // Segment base offsets the linear address in protected mode only
    epbc_sw_model_i.wr(OFS_DS_BASE, 32'h1000);
    map_set(0, 7'h01);
    leaf_chk(CB - 32'h1000, success_code, 32'h0, 32'h2);
    rdc(OFS_MAP_DATA, 32'h03);
    epbc_sw_model_i.wr(OFS_MODE, 32'h4);
    epbc_sw_model_i.wr(OFS_ADDR_HI, 32'h0001_0000);
    leaf_chk(CB, success_code, 32'h0, 32'h6);
    epbc_sw_model_i.wr(OFS_ADDR_HI, 32'h0);
    map_set(0, 7'h01);
    leaf_chk(CB, success_code, 32'h0, 32'h2);
    epbc_sw_model_i.wr(OFS_MODE, 32'h0);
    // A start with any other selector is ignored
    n0 = done_seen;
    epbc_sw_model_i.wr(OFS_LEAF, 32'h08);
    repeat (6) @(posedge clk);
    chk(done_seen, n0);
    rdc(8'h40, 32'h0);
    chk({30'h0, hresp, hreadyout}, 32'h1);
    // Second reset in mid-run, then reset values
    @(posedge clk) nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rdc(OFS_DS_LIMIT, RST_DS_LIMIT);
    rdc(OFS_RESULT, RST_WORD);
    rdc(OFS_FLAGS, RST_WORD);
    rdc(OFS_MODE, RST_WORD);
    rdc(OFS_MAP_DATA, RST_WORD);
    results();
  end
endmodule : tb_top

`default_nettype wire
